/* File: hdl/seeq_map.vh */
// address map, field positions and fixed values of the status and error queue bank
// assumes a 32-bit classic wishbone slave with byte addresses on wb_adr_i
`ifndef SEEQ_MAP_VH
`define SEEQ_MAP_VH
// register sets: 0 meas, 1 ques, 2 oper, 3 trig, 4 arm, 5 seq
`define SEEQ_NSETS 6
`define SEEQ_FIRST_ONES 3
`define SEEQ_SET_ARM 4
`define SEEQ_SET_SEQ 5
// per-set registers, set base = set index * 32 bytes, word index in adr[4:2]
`define SEEQ_F_COND 3'h0
`define SEEQ_F_EVENT 3'h1
`define SEEQ_F_ENAB 3'h2
`define SEEQ_F_PTR 3'h3
`define SEEQ_F_NTR 3'h4
// shared registers
`define SEEQ_A_CTRL 8'hc0
`define SEEQ_A_QDATA 8'hc4
`define SEEQ_A_QSTAT 8'hc8
`define SEEQ_A_ENSEL 8'hcc
`define SEEQ_A_ENWIN 8'hd0
`define SEEQ_A_RANGE 8'hd4
// control bits
`define SEEQ_B_PRESET 0
`define SEEQ_B_QCLR 1
`define SEEQ_B_DISALL 2
`define SEEQ_B_ENRNG 3
`define SEEQ_B_DISRNG 4
// preset values
`define SEEQ_PTR_PRESET 16'hffff
`define SEEQ_NTR_PRESET 16'h0000
`define SEEQ_ENAB_ZERO 16'h0000
`define SEEQ_ENAB_ONES 16'hffff
// error queue
`define SEEQ_QDEPTH 4'ha
`define SEEQ_QLAST 4'h9
`define SEEQ_OVF_CODE 11'sd350
`define SEEQ_NOERR_CODE 11'sd0
`define SEEQ_CODE_SIGN 11'h400
`define SEEQ_STAT_LO 11'sd100
`define SEEQ_STAT_HI 11'sd199
// enable walker states
`define SEEQ_W_IDLE 2'h0
`define SEEQ_W_INIT 2'h1
`define SEEQ_W_ALL 2'h2
`define SEEQ_W_RNG 2'h3
// enable table index span walked by a full fill or clear
`define SEEQ_EN_FIRST 11'h000
`define SEEQ_EN_LAST 11'h7ff
`endif

/* File: hdl/seeq_top.v */
// status condition, transition filter, event and enable registers plus the error queue
// assumes a classic wishbone master on clk_sys_i and condition lines from other clocks
`timescale 1ns/1ps
`include "seeq_map.vh"

module seeq_top (
  input wire clk_sys_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire [15:0] cond_meas_i,
  input wire [15:0] cond_ques_i,
  input wire [15:0] cond_oper_i,
  input wire [15:0] cond_trig_i,
  input wire [15:0] cond_arm_i,
  input wire [15:0] cond_seq_i,
  input wire msg_valid_i,
  input wire [10:0] msg_code_i,
  output reg q_empty_o,
  output reg q_ovf_o,
  output reg en_busy_o
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // offset binary index of a signed code into the enable table
  function [10:0] code_idx;
    input [10:0] code;
    begin
      code_idx = code ^ `SEEQ_CODE_SIGN;
    end
  endfunction

  function [3:0] q_inc;
    input [3:0] p;
    begin
      q_inc = (p == `SEEQ_QLAST) ? 4'h0 : p + 4'h1;
    end
  endfunction

  // status messages start disabled, every other code enabled
  function en_default;
    input [10:0] idx;
    reg signed [10:0] c;
    begin
      c = idx ^ `SEEQ_CODE_SIGN;
      en_default = !((c >= `SEEQ_STAT_LO) && (c <= `SEEQ_STAT_HI));
    end
  endfunction

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // partial writes are ignored so that no half-updated word reaches the logic
  wire wr = req & wb_we_i & (wb_sel_i == 4'hf);
  wire rd = req & ~wb_we_i;
  wire [2:0] set_sel = wb_adr_i[7:5];
  wire [2:0] fld_sel = wb_adr_i[4:2];
  wire in_set = (set_sel < `SEEQ_NSETS) && (wb_adr_i[1:0] == 2'h0);
  wire wr_ctrl = wr & (wb_adr_i == `SEEQ_A_CTRL);
  wire preset = wr_ctrl & wb_dat_i[`SEEQ_B_PRESET];

  // ---------------------------------------------------------------
  // condition, filter, event and enable registers
  // ---------------------------------------------------------------
  wire [95:0] cond_all = {cond_seq_i, cond_arm_i, cond_trig_i, cond_oper_i, cond_ques_i, cond_meas_i};
  reg [15:0] c1_r [0:5];
  reg [15:0] c2_r [0:5];
  reg [15:0] c3_r [0:5];
  reg [15:0] ptr_r [0:5];
  reg [15:0] ntr_r [0:5];
  reg [15:0] evt_r [0:5];
  reg [15:0] ene_r [0:5];
  integer i, k;

  always @(posedge clk_sys_i) begin
    for (k = 0; k < `SEEQ_NSETS; k = k + 1) begin
      // conditions cross in from the instrument, so two flops first
      c1_r[k] <= cond_all[k*16 +: 16];
      c2_r[k] <= c1_r[k];
      c3_r[k] <= c2_r[k];
    end
  end

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      for (i = 0; i < `SEEQ_NSETS; i = i + 1) begin
        ptr_r[i] <= `SEEQ_PTR_PRESET;
        ntr_r[i] <= `SEEQ_NTR_PRESET;
        evt_r[i] <= 16'h0000;
        ene_r[i] <= (i < `SEEQ_FIRST_ONES) ? `SEEQ_ENAB_ZERO : `SEEQ_ENAB_ONES;
      end
    end else begin
      for (i = 0; i < `SEEQ_NSETS; i = i + 1) begin
        // a filtered edge in the read cycle survives the read clear
        evt_r[i] <= (evt_r[i] & ~{16{rd & in_set & (set_sel == i) & (fld_sel == `SEEQ_F_EVENT)}})
                    | (c2_r[i] & ~c3_r[i] & ptr_r[i])
                    | (~c2_r[i] & c3_r[i] & ntr_r[i]);
        if (preset) begin
          ptr_r[i] <= `SEEQ_PTR_PRESET;
          ntr_r[i] <= `SEEQ_NTR_PRESET;
          if (i < `SEEQ_FIRST_ONES) begin
            ene_r[i] <= `SEEQ_ENAB_ZERO;
          end else begin
            ene_r[i] <= `SEEQ_ENAB_ONES;
          end
        end else if (wr & in_set & (set_sel == i)) begin
          if (fld_sel == `SEEQ_F_PTR) begin
            ptr_r[i] <= wb_dat_i[15:0];
          end
          if (fld_sel == `SEEQ_F_NTR) begin
            ntr_r[i] <= wb_dat_i[15:0];
          end
          if (fld_sel == `SEEQ_F_ENAB) begin
            ene_r[i] <= wb_dat_i[15:0];
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // message enable table and its walker
  // ---------------------------------------------------------------
  reg en_mem [0:2047];
  reg [1:0] w_st_r;
  reg [10:0] w_idx_r;
  reg [10:0] w_end_r;
  reg w_val_r;
  reg w_pend_r;
  reg [10:0] r_lo_r;
  reg [10:0] r_hi_r;
  reg [10:0] r_beg_r;
  reg [10:0] r_fin_r;
  reg [5:0] ensel_r;
  localparam [1:0] W_IDLE = `SEEQ_W_IDLE;
  localparam [1:0] W_INIT = `SEEQ_W_INIT;
  localparam [1:0] W_ALL = `SEEQ_W_ALL;
  localparam [1:0] W_RNG = `SEEQ_W_RNG;
  wire w_busy = (w_st_r != W_IDLE);
  wire w_last = (w_idx_r == w_end_r);
  wire [10:0] lo_idx = code_idx(wb_dat_i[10:0]);
  wire [10:0] hi_idx = code_idx(wb_dat_i[26:16]);

  always @(posedge clk_sys_i) begin
    if (w_busy) begin
      en_mem[w_idx_r] <= (w_st_r == W_INIT) ? en_default(w_idx_r) : w_val_r;
    end
  end

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      w_st_r <= W_INIT;
      w_idx_r <= `SEEQ_EN_FIRST;
      w_end_r <= `SEEQ_EN_LAST;
      w_val_r <= 1'b0;
      w_pend_r <= 1'b0;
      r_beg_r <= 11'h000;
      r_fin_r <= 11'h000;
      ensel_r <= 6'h00;
    end else begin
      if (wr & (wb_adr_i == `SEEQ_A_ENSEL)) begin
        ensel_r <= wb_dat_i[5:0];
      end
      // a descending range walks the same codes as its ascending twin
      if (wr & (wb_adr_i == `SEEQ_A_RANGE)) begin
        r_beg_r <= (lo_idx < hi_idx) ? lo_idx : hi_idx;
        r_fin_r <= (lo_idx < hi_idx) ? hi_idx : lo_idx;
      end
      case (w_st_r)
        W_IDLE: begin
          // commands arriving while a walk runs are dropped; software polls busy
          if (wr_ctrl & wb_dat_i[`SEEQ_B_DISALL]) begin
            w_st_r <= W_ALL;
            w_idx_r <= `SEEQ_EN_FIRST;
            w_end_r <= `SEEQ_EN_LAST;
            w_val_r <= 1'b0;
            w_pend_r <= wb_dat_i[`SEEQ_B_ENRNG];
          end else if (wr_ctrl & (wb_dat_i[`SEEQ_B_ENRNG] | wb_dat_i[`SEEQ_B_DISRNG])) begin
            w_st_r <= W_RNG;
            w_idx_r <= r_beg_r;
            w_end_r <= r_fin_r;
            w_val_r <= wb_dat_i[`SEEQ_B_ENRNG];
          end
        end
        W_INIT, W_RNG: begin
          if (w_last) begin
            w_st_r <= W_IDLE;
          end else begin
            w_idx_r <= w_idx_r + 11'h001;
          end
        end
        W_ALL: begin
          if (w_last & w_pend_r) begin
            w_st_r <= W_RNG;
            w_idx_r <= r_beg_r;
            w_end_r <= r_fin_r;
            w_val_r <= 1'b1;
            w_pend_r <= 1'b0;
          end else if (w_last) begin
            w_st_r <= W_IDLE;
          end else begin
            w_idx_r <= w_idx_r + 11'h001;
          end
        end
        default: begin
          w_st_r <= W_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // error queue
  // ---------------------------------------------------------------
  reg signed [10:0] q_mem [0:9];
  reg [3:0] q_rd_r;
  reg [3:0] q_wr_r;
  reg [3:0] q_cnt_r;
  reg q_ovf_r;
  reg [3:0] q_cnt_nxt;
  // messages during the power-up table fill are lost: the table is not valid yet
  wire push = msg_valid_i & (w_st_r != W_INIT) & en_mem[code_idx(msg_code_i)] & (q_cnt_r < `SEEQ_QDEPTH);
  wire pop = rd & (wb_adr_i == `SEEQ_A_QDATA) & (q_cnt_r != 4'h0);
  wire qclr = wr_ctrl & wb_dat_i[`SEEQ_B_QCLR];

  always @* begin
    q_cnt_nxt = q_cnt_r;
    if (qclr) begin
      q_cnt_nxt = 4'h0;
    end else if (push & ~pop) begin
      q_cnt_nxt = q_cnt_r + 4'h1;
    end else if (pop & ~push) begin
      q_cnt_nxt = q_cnt_r - 4'h1;
    end
  end

  always @(posedge clk_sys_i) begin
    if (push & ~qclr) begin
      // the tenth slot only ever takes the overflow marker
      q_mem[q_wr_r] <= ((q_cnt_r == `SEEQ_QLAST) & ~pop) ? `SEEQ_OVF_CODE : msg_code_i;
    end
  end

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      q_rd_r <= 4'h0;
      q_wr_r <= 4'h0;
      q_cnt_r <= 4'h0;
      q_ovf_r <= 1'b0;
    end else if (qclr) begin
      q_rd_r <= 4'h0;
      q_wr_r <= 4'h0;
      q_cnt_r <= 4'h0;
      q_ovf_r <= 1'b0;
    end else begin
      q_cnt_r <= q_cnt_nxt;
      if (push) begin
        q_wr_r <= q_inc(q_wr_r);
      end
      if (pop) begin
        q_rd_r <= q_inc(q_rd_r);
      end
      if (push & ~pop & (q_cnt_r == `SEEQ_QLAST)) begin
        q_ovf_r <= 1'b1;
      end else if (q_cnt_nxt == 4'h0) begin
        q_ovf_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // read mux and bus answer
  // ---------------------------------------------------------------
  reg [31:0] rdata;
  reg [15:0] sreg;
  integer j;

  always @* begin
    rdata = 32'h00000000;
    sreg = 16'h0000;
    if (in_set) begin
      case (fld_sel)
        `SEEQ_F_COND: sreg = c2_r[set_sel];
        `SEEQ_F_EVENT: sreg = evt_r[set_sel];
        `SEEQ_F_ENAB: sreg = ene_r[set_sel];
        `SEEQ_F_PTR: sreg = ptr_r[set_sel];
        `SEEQ_F_NTR: sreg = ntr_r[set_sel];
        default: sreg = 16'h0000;
      endcase
      rdata = {16'h0000, sreg};
    end else begin
      case (wb_adr_i)
        `SEEQ_A_QDATA: begin
          if (q_cnt_r == 4'h0) begin
            rdata = {{21{1'h0}}, `SEEQ_NOERR_CODE};
          end else begin
            rdata = {{21{q_mem[q_rd_r][10]}}, q_mem[q_rd_r]};
          end
        end
        `SEEQ_A_QSTAT: rdata = {25'h0000000, w_busy, q_ovf_r, (q_cnt_r == 4'h0), q_cnt_r};
        `SEEQ_A_ENSEL: rdata = {26'h0000000, ensel_r};
        `SEEQ_A_ENWIN: begin
          for (j = 0; j < 32; j = j + 1) begin
            rdata[j] = en_mem[{ensel_r, j[4:0]}];
          end
        end
        `SEEQ_A_RANGE: rdata = {5'h00, r_fin_r, 5'h00, r_beg_r};
        default: rdata = 32'h00000000;
      endcase
    end
  end

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      q_empty_o <= 1'b1;
      q_ovf_o <= 1'b0;
      en_busy_o <= 1'b1;
    end else begin
      wb_ack_o <= req;
      if (rd) begin
        wb_dat_o <= rdata;
      end
      q_empty_o <= (q_cnt_r == 4'h0);
      q_ovf_o <= q_ovf_r;
      en_busy_o <= w_busy;
    end
  end

endmodule

/* File: dv/seeq_checker.sv */
// port assertions for the status, event and error queue bank
// assumes seeq_top ports and the map header; one clock, synchronous reset
`timescale 1ns/1ps
`include "seeq_map.vh"
module seeq_checker (
  input wire clk_sys_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire [15:0] cond_meas_i,
  input wire [15:0] cond_ques_i,
  input wire [15:0] cond_oper_i,
  input wire [15:0] cond_trig_i,
  input wire [15:0] cond_arm_i,
  input wire [15:0] cond_seq_i,
  input wire msg_valid_i,
  input wire [10:0] msg_code_i,
  input wire q_empty_o,
  input wire q_ovf_o,
  input wire en_busy_o
);
  // ----
  // request decode and sequences
  // ----
  wire req_w = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire rd_w = req_w && !wb_we_i;
  wire wr_w = req_w && wb_we_i && wb_sel_i == 4'hf;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // five quiet edges cover the two sync flops plus the condition register
  sequence meas_steady; $stable(cond_meas_i)[*5]; endsequence
  sequence clr_taken;
    (wr_w && wb_adr_i == `SEEQ_A_CTRL && wb_dat_i[`SEEQ_B_QCLR] && !msg_valid_i) ##1 !msg_valid_i;
  endsequence
  ack_answer_a: assert property (req_w |=> wb_ack_o) else $error("request not answered");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  dat_hold_a: assert property (!wb_ack_o |-> $stable(wb_dat_o)) else $error("read data moved");
  cond_read_a: assert property (meas_steady ##0 (rd_w && wb_adr_i == 8'h00)
    |=> wb_dat_o == {16'h0000, $past(cond_meas_i)}) else $error("condition read not live");
  empty_read_a: assert property ((q_empty_o && !msg_valid_i && !$past(msg_valid_i))
    && rd_w && wb_adr_i == `SEEQ_A_QDATA |=> wb_dat_o == 32'h0) else $error("empty read not zero");
  clr_empty_a: assert property (clr_taken |=> q_empty_o && !q_ovf_o) else $error("clear left entries");
  ovf_flag_a: assert property (q_ovf_o |-> !q_empty_o) else $error("overflow on empty queue");
  reset_queue_a: assert property ($past(rst_i) |-> q_empty_o && !q_ovf_o) else $error("queue not empty");
  reset_busy_a: assert property ($past(rst_i) |-> en_busy_o) else $error("enable fill not started");
endmodule
bind seeq_top seeq_checker seeq_checker_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cond_meas_i(cond_meas_i), .cond_ques_i(cond_ques_i),
  .cond_oper_i(cond_oper_i), .cond_trig_i(cond_trig_i), .cond_arm_i(cond_arm_i), .cond_seq_i(cond_seq_i),
  .msg_valid_i(msg_valid_i), .msg_code_i(msg_code_i), .q_empty_o(q_empty_o), .q_ovf_o(q_ovf_o),
  .en_busy_o(en_busy_o));

/* File: dv/seeq_host_model.sv */
// host side of the command bus: classic wishbone single cycles
// assumes a slave that acks once per request; waits are ended by the bench timeout
`timescale 1ns/1ps
module seeq_host_model (
  input wire clk_sys_i,
  input wire ack_i,
  input wire [31:0] rdat_i,
  output reg cyc_o,
  output reg stb_o,
  output reg we_o,
  output reg [7:0] adr_o,
  output reg [3:0] sel_o,
  output reg [31:0] wdat_o
);
  initial begin
    cyc_o = 1'h0;
    stb_o = 1'h0;
    we_o = 1'h0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    wdat_o = 32'h0;
  end
  // ----
  // one transfer, held until ack is sampled
  // ----
  task xfer(input w, input [7:0] a, input [31:0] d, output [31:0] q);
    @(posedge clk_sys_i);
    cyc_o <= 1'h1;
    stb_o <= 1'h1;
    we_o <= w;
    adr_o <= a;
    sel_o <= 4'hf;
    wdat_o <= d;
    do @(posedge clk_sys_i); while (ack_i !== 1'h1);
    q = rdat_i;
    cyc_o <= 1'h0;
    stb_o <= 1'h0;
    // released address and write data lines show the inverse so stale values never pass
    adr_o <= ~a;
    wdat_o <= ~d;
  endtask
endmodule

/* File: dv/seeq_tb_top.sv */
// self-checking bench for the status, event and error queue bank
// assumes seeq_top, the host model and the bound checker
`timescale 1ns/1ps
`include "seeq_map.vh"
module seeq_tb_top;
  reg clk_sys_i = 1'h0;
  reg rst_i = 1'h1;
  reg [15:0] cnd [0:5];
  reg msg_valid_i = 1'h0;
  reg [10:0] msg_code_i = 11'h0;
  wire cyc, stb, we, ack, q_empty_o, q_ovf_o, en_busy_o;
  wire [7:0] adr;
  wire [3:0] sel;
  wire [31:0] wdat, rdat;
  integer err_total = 0;
  integer checks = 0;
  integer cyc_n = 0;
  integer i;
  reg [31:0] q;
  always #12.5 clk_sys_i = ~clk_sys_i;
  seeq_top seeq_top_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .cond_meas_i(cnd[0]),
    .cond_ques_i(cnd[1]), .cond_oper_i(cnd[2]), .cond_trig_i(cnd[3]), .cond_arm_i(cnd[4]), .cond_seq_i(cnd[5]),
    .msg_valid_i(msg_valid_i), .msg_code_i(msg_code_i), .q_empty_o(q_empty_o), .q_ovf_o(q_ovf_o),
    .en_busy_o(en_busy_o));
  seeq_host_model seeq_host_model_inst (.clk_sys_i(clk_sys_i), .ack_i(ack), .rdat_i(rdat), .cyc_o(cyc),
    .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .wdat_o(wdat));
  // ----
  // helpers
  // ----
  function [7:0] ra(input [2:0] s, input [2:0] f);
    ra = {s, f, 2'h0};
  endfunction
  task chk(input string nm, input [31:0] e, input [31:0] g);
    checks = checks + 1;
    if (g !== e) begin
      err_total = err_total + 1;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task rd(input [7:0] a, input [31:0] e, input string nm);
    seeq_host_model_inst.xfer(1'h0, a, 32'h0, q);
    chk(nm, e, q);
  endtask
  task wr(input [7:0] a, input [31:0] d);
    seeq_host_model_inst.xfer(1'h1, a, d, q);
  endtask
  task idle(input integer n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task push(input [10:0] c);
    @(posedge clk_sys_i);
    msg_valid_i <= 1'h1;
    msg_code_i <= c;
    @(posedge clk_sys_i);
    msg_valid_i <= 1'h0;
    @(posedge clk_sys_i);
  endtask
  task wait_busy;
    idle(3);
    for (i = 0; i < 3000 && en_busy_o !== 1'h0; i = i + 1) @(posedge clk_sys_i);
    @(negedge clk_sys_i) chk("busy", 32'h0, {31'h0, en_busy_o});
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  task t_reset;
    for (i = 0; i < 6; i = i + 1) begin
      rd(ra(i[2:0], `SEEQ_F_ENAB), i < 3 ? 32'h0 : 32'hffff, "enab");
      rd(ra(i[2:0], `SEEQ_F_PTR), 32'hffff, "ptr");
      rd(ra(i[2:0], `SEEQ_F_NTR), 32'h0, "ntr");
    end
    rd(`SEEQ_A_QDATA, 32'h0, "qdata");
    rd(8'hf0, 32'h0, "unmapped");
    $display("reset test done");
  endtask
  task t_cond;
    for (i = 0; i < 6; i = i + 1) cnd[i] <= 16'h0200 >> i;
    idle(6);
    for (i = 0; i < 6; i = i + 1) rd(ra(i[2:0], `SEEQ_F_COND), 32'h200 >> i, "cond");
    for (i = 0; i < 6; i = i + 1) cnd[i] <= 16'h0;
    idle(6);
    for (i = 0; i < 6; i = i + 1) rd(ra(i[2:0], `SEEQ_F_COND), 32'h0, "cond low");
    $display("condition test done");
  endtask
  task t_filter;
    rd(ra(3'h4, `SEEQ_F_EVENT), 32'h20, "arm rise");
    rd(ra(3'h5, `SEEQ_F_EVENT), 32'h10, "seq rise");
    wr(ra(3'h4, `SEEQ_F_PTR), 32'h0);
    wr(ra(3'h4, `SEEQ_F_NTR), 32'h2);
    wr(ra(3'h5, `SEEQ_F_PTR), 32'h0);
    wr(ra(3'h5, `SEEQ_F_NTR), 32'h6);
    cnd[4] <= 16'h0002;
    cnd[5] <= 16'h0006;
    idle(6);
    rd(ra(3'h4, `SEEQ_F_EVENT), 32'h0, "arm enter");
    rd(ra(3'h5, `SEEQ_F_EVENT), 32'h0, "seq enter");
    cnd[4] <= 16'h0;
    cnd[5] <= 16'h0004;
    idle(6);
    rd(ra(3'h4, `SEEQ_F_EVENT), 32'h2, "arm leave");
    rd(ra(3'h5, `SEEQ_F_EVENT), 32'h2, "seq layer1");
    cnd[5] <= 16'h0;
    idle(6);
    rd(ra(3'h5, `SEEQ_F_EVENT), 32'h4, "seq layer2");
    rd(ra(3'h4, `SEEQ_F_EVENT), 32'h0, "arm reread");
    $display("filter test done");
  endtask
  task t_queue;
    push(11'h7fb);
    push(11'h007);
    push(11'h12c);
    rd(`SEEQ_A_QDATA, 32'hfffffffb, "q neg");
    rd(`SEEQ_A_QDATA, 32'h7, "q 2nd");
    rd(`SEEQ_A_QDATA, 32'h12c, "q 3rd");
    rd(`SEEQ_A_QDATA, 32'h0, "q none");
    for (i = 1; i < 13; i = i + 1) push(i[10:0]);
    @(negedge clk_sys_i) chk("ovf", 32'h1, {31'h0, q_ovf_o});
    rd(`SEEQ_A_QSTAT, 32'h2a, "qstat full");
    for (i = 1; i < 10; i = i + 1) rd(`SEEQ_A_QDATA, i, "q fill");
    rd(`SEEQ_A_QDATA, 32'h15e, "q last");
    rd(`SEEQ_A_QDATA, 32'h0, "q after");
    push(11'h096);
    push(11'h79c);
    rd(`SEEQ_A_QDATA, 32'hffffff9c, "status blocked");
    push(11'h003);
    push(11'h004);
    wr(`SEEQ_A_CTRL, 32'h2);
    @(negedge clk_sys_i) chk("q empty", 32'h1, {31'h0, q_empty_o});
    rd(`SEEQ_A_QDATA, 32'h0, "cleared");
    $display("queue test done");
  endtask
  task t_preset;
    wr(ra(3'h0, `SEEQ_F_ENAB), 32'h1234);
    wr(ra(3'h0, `SEEQ_F_NTR), 32'hff);
    wr(ra(3'h3, `SEEQ_F_PTR), 32'h0);
    wr(ra(3'h4, `SEEQ_F_ENAB), 32'h0);
    wr(`SEEQ_A_ENSEL, 32'h5);
    wr(`SEEQ_A_CTRL, 32'h1);
    rd(ra(3'h0, `SEEQ_F_ENAB), 32'h0, "meas enab");
    rd(ra(3'h0, `SEEQ_F_NTR), 32'h0, "meas ntr");
    rd(ra(3'h3, `SEEQ_F_PTR), 32'hffff, "trig ptr");
    rd(ra(3'h4, `SEEQ_F_ENAB), 32'hffff, "arm enab");
    rd(`SEEQ_A_ENSEL, 32'h5, "ensel kept");
    $display("preset test done");
  endtask
  task t_enlist;
    wr(`SEEQ_A_RANGE, 32'h00060005);
    rd(`SEEQ_A_RANGE, 32'h04060405, "range back");
    wr(`SEEQ_A_CTRL, 32'hc);
    wait_busy;
    push(11'h004);
    push(11'h005);
    push(11'h006);
    rd(`SEEQ_A_QDATA, 32'h5, "listed a");
    rd(`SEEQ_A_QDATA, 32'h6, "listed b");
    rd(`SEEQ_A_QDATA, 32'h0, "unlisted");
    wr(`SEEQ_A_ENSEL, 32'h20);
    rd(`SEEQ_A_ENWIN, 32'h60, "enable query");
    wr(`SEEQ_A_RANGE, 32'h00050005);
    wr(`SEEQ_A_CTRL, 32'h10);
    wait_busy;
    push(11'h005);
    push(11'h006);
    rd(`SEEQ_A_QDATA, 32'h6, "disabled");
    wr(`SEEQ_A_CTRL, 32'h4);
    wait_busy;
    push(11'h006);
    rd(`SEEQ_A_QDATA, 32'h0, "empty list");
    $display("enable list test done");
  endtask
  initial begin
    for (i = 0; i < 6; i = i + 1) cnd[i] = 16'h0;
    repeat (8) @(posedge clk_sys_i);
    rst_i <= 1'h0;
    t_reset;
    t_cond;
    t_filter;
    wait_busy;
    t_queue;
    t_preset;
    t_enlist;
    wrap_up;
  end
  // ceiling: one fill and two full walks of about 2050 cycles plus short range walks and bus traffic
  always @(posedge clk_sys_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      err_total = err_total + 1;
      wrap_up;
    end
  end
endmodule
